// ---- design/dca_align_ctrl.sv ----
`timescale 1ns/100ps
`include "dca_map.svh"

module dca_align_ctrl (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic host_data_clock_in_i,
    input wire logic spi_sclk_i,
    input wire logic spi_csb_i,
    input wire logic spi_sdio_i,
    output logic spi_sdio_o,
    output logic spi_sdio_oe_n_o,
    input wire dca_pkg::dca_window_t window_i,
    input wire logic [4:0] domain_phase_i,
    output logic irq_o,
    output logic [9:0] input_clock_delay_o,
    output logic [9:0] sample_clock_delay_o,
    output logic [3:0] sampling_window_skew_o,
    output logic [8:0] domain_phase_delay_o,
    output logic clock_out_power_down_o,
    output logic lvds_rx_power_down_o
);
    import dca_pkg::*;

    // Link side: window taps sampled on the host clock, handed over by toggle
    logic lrst_meta_q, lrst_n_q;
    dca_window_t lwin_meta_q, lwin_q, lword_q;
    logic lreq_q, lack_meta_q, lack_q;
    logic creq_meta_q, creq_q, cack_q;
    logic smp_vld_q;
    dca_window_t smp_win_q;

    always_ff @(posedge host_data_clock_in_i) begin
        lrst_meta_q <= rst_n_i;
        lrst_n_q <= lrst_meta_q;
    end

    always_ff @(posedge host_data_clock_in_i) begin
        if (!lrst_n_q) begin
            lwin_meta_q <= '0;
            lwin_q <= '0;
            lword_q <= '0;
            lreq_q <= 1'b0;
            lack_meta_q <= 1'b0;
            lack_q <= 1'b0;
        end else begin
            lwin_meta_q <= window_i;
            lwin_q <= lwin_meta_q;
            lack_meta_q <= cack_q;
            lack_q <= lack_meta_q;
            // Word only changes while no handover is pending, so the core may read it
            if (lreq_q == lack_q) begin
                lword_q <= lwin_q;
                lreq_q <= ~lreq_q;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            creq_meta_q <= 1'b0;
            creq_q <= 1'b0;
            cack_q <= 1'b0;
            smp_vld_q <= 1'b0;
            smp_win_q <= '0;
        end else begin
            creq_meta_q <= lreq_q;
            creq_q <= creq_meta_q;
            smp_vld_q <= (creq_q != cack_q);
            if (creq_q != cack_q) begin
                smp_win_q <= lword_q;
                cack_q <= creq_q;
            end
        end
    end

    // Pin synchronisers; the third sclk stage only feeds edge detection
    logic [2:0] sclk_q;
    logic [1:0] csb_q, sdio_q;
    logic [4:0] ph_meta_q, ph_q, ph_prev_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sclk_q <= '0;
            csb_q <= 2'b11;
            sdio_q <= '0;
            ph_meta_q <= '0;
            ph_q <= '0;
            ph_prev_q <= '0;
        end else begin
            sclk_q <= {sclk_q[1:0], spi_sclk_i};
            csb_q <= {csb_q[0], spi_csb_i};
            sdio_q <= {sdio_q[0], spi_sdio_i};
            ph_meta_q <= domain_phase_i;
            ph_q <= ph_meta_q;
            ph_prev_q <= ph_q;
        end
    end

    // Phase code is quasi-static; two equal samples mark it settled
    wire ph_stable = (ph_q == ph_prev_q);
    wire sclk_rise = sclk_q[1] & ~sclk_q[2];
    wire sclk_fall = ~sclk_q[1] & sclk_q[2];

    // Serial port: instruction byte (read flag, 7-bit address) then one data byte
    logic [4:0] bit_cnt_q;
    logic [6:0] sh_q;
    logic rd_q;
    logic [6:0] addr_q;
    logic [7:0] rd_sh_q;
    logic wr_stb_q;
    dca_wr_t wr_q;
    logic [7:0] rd_data;
    wire [6:0] instr_addr = {sh_q[5:0], sdio_q[1]};

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || csb_q[1]) begin
            bit_cnt_q <= '0;
            sh_q <= '0;
            rd_q <= 1'b0;
            addr_q <= '0;
            rd_sh_q <= '0;
            wr_stb_q <= 1'b0;
            wr_q <= '0;
            spi_sdio_o <= 1'b0;
            spi_sdio_oe_n_o <= 1'b1;
        end else begin
            wr_stb_q <= 1'b0;
            if (sclk_rise) begin
                sh_q <= {sh_q[5:0], sdio_q[1]};
                if (bit_cnt_q != 5'h10) begin
                    bit_cnt_q <= bit_cnt_q + 5'h01;
                end
                if (bit_cnt_q == 5'h07) begin
                    rd_q <= sh_q[6];
                    addr_q <= instr_addr;
                    rd_sh_q <= rd_data;
                end
                if (bit_cnt_q == 5'h0F && !rd_q) begin
                    wr_q <= '{addr: addr_q, data: {sh_q, sdio_q[1]}};
                    wr_stb_q <= 1'b1;
                end
            end
            if (sclk_fall && rd_q && bit_cnt_q >= 5'h08 && bit_cnt_q != 5'h10) begin
                spi_sdio_o <= rd_sh_q[7];
                rd_sh_q <= {rd_sh_q[6:0], 1'b0};
                spi_sdio_oe_n_o <= 1'b0;
            end
        end
    end

    function automatic logic wr_hit(input logic [6:0] a);
        wr_hit = wr_stb_q && (wr_q.addr == a);
    endfunction

    // Host registers
    logic [7:0] pwr_q, rx_ctl_q, mu_ctl_q, guard_q;
    logic [3:0] irq_en_q, irq_st_q, skew_q;
    logic [1:0] skew_spare_q;
    logic [4:0] mu_tgt_q;
    logic mu_slope_neg_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pwr_q <= '0;
            rx_ctl_q <= '0;
            mu_ctl_q <= '0;
            guard_q <= `DCA_GUARD_RST;
            irq_en_q <= '0;
            skew_q <= `DCA_SKEW_RST;
            skew_spare_q <= '0;
            mu_tgt_q <= `DCA_MU_TGT_RST;
            mu_slope_neg_q <= 1'b0;
        end else begin
            if (wr_hit(`DCA_A_PWR)) pwr_q <= wr_q.data;
            if (wr_hit(`DCA_A_RX_CTL)) rx_ctl_q <= wr_q.data;
            if (wr_hit(`DCA_A_MU_CTL)) mu_ctl_q <= wr_q.data;
            if (wr_hit(`DCA_A_MU_GUARD)) guard_q <= wr_q.data;
            if (wr_hit(`DCA_A_IRQ_EN)) irq_en_q <= wr_q.data[3:0];
            if (wr_hit(`DCA_A_CLK_SKEW)) begin
                skew_q <= wr_q.data[3:0];
                skew_spare_q <= wr_q.data[5:4];
            end
            if (wr_hit(`DCA_A_MU_HI)) begin
                mu_tgt_q <= wr_q.data[4:0];
                mu_slope_neg_q <= wr_q.data[6];
            end
        end
    end

    // Receiver alignment loop
    dca_rx_state_t rx_state_q;
    logic [9:0] clk_dly_q, smp_dly_q, init_q, up_dist_q;
    logic up_found_q, rx_lock_q, rx_lost_q;
    logic [11:0] rx_timer_q;
    wire rx_edge = ~smp_win_q.pre & smp_win_q.post;
    wire rx_start = wr_hit(`DCA_A_RX_CTL) && wr_q.data[`DCA_RXC_RUN]
        && (!rx_ctl_q[`DCA_RXC_RUN] || !rx_lock_q);
    wire [9:0] dn_dist = init_q - clk_dly_q;
    wire rx_track_on = (rx_state_q == DCA_RX_TRACK) && rx_ctl_q[`DCA_RXC_TRACK];
    logic rx_lost_set;
    logic [9:0] rx_dly_prev_q;
    logic rx_skip_q;
    // A word in flight when the delay moves still shows the old setting, so drop it
    wire rx_vld = smp_vld_q && !rx_skip_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_dly_prev_q <= `DCA_DLY_RST;
            rx_skip_q <= 1'b0;
        end else begin
            rx_dly_prev_q <= clk_dly_q;
            if (clk_dly_q != rx_dly_prev_q) begin
                rx_skip_q <= 1'b1;
            end else if (smp_vld_q) begin
                rx_skip_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_state_q <= DCA_RX_IDLE;
            clk_dly_q <= `DCA_DLY_RST;
            smp_dly_q <= `DCA_DLY_RST;
            init_q <= '0;
            up_dist_q <= '0;
            up_found_q <= 1'b0;
            rx_lock_q <= 1'b0;
            rx_lost_set <= 1'b0;
            rx_timer_q <= '0;
        end else begin
            rx_lost_set <= 1'b0;
            if (rx_state_q == DCA_RX_IDLE) begin
                if (wr_hit(`DCA_A_CLK_SKEW)) clk_dly_q[1:0] <= wr_q.data[7:6];
                if (wr_hit(`DCA_A_CLK_HI)) clk_dly_q[9:2] <= wr_q.data;
                if (wr_hit(`DCA_A_SMP_LO)) smp_dly_q[7:0] <= wr_q.data;
                if (wr_hit(`DCA_A_SMP_HI)) smp_dly_q[9:8] <= wr_q.data[1:0];
            end else begin
                smp_dly_q <= clk_dly_q;
                rx_timer_q <= rx_timer_q + 12'h001;
            end
            if (!rx_ctl_q[`DCA_RXC_RUN] && !rx_start) begin
                rx_state_q <= DCA_RX_IDLE;
                rx_lock_q <= 1'b0;
            end else begin
                case (rx_state_q)
                    DCA_RX_IDLE: begin
                        if (rx_start) begin
                            init_q <= clk_dly_q;
                            up_found_q <= 1'b0;
                            rx_timer_q <= '0;
                            rx_lock_q <= 1'b0;
                            rx_state_q <= DCA_RX_UP;
                        end
                    end
                    DCA_RX_UP: begin
                        if (rx_vld) begin
                            if (rx_edge || clk_dly_q == `DCA_DLY_MAX) begin
                                up_found_q <= rx_edge;
                                up_dist_q <= clk_dly_q - init_q;
                                clk_dly_q <= init_q;
                                rx_state_q <= DCA_RX_DOWN;
                            end else begin
                                clk_dly_q <= clk_dly_q + 10'h001;
                            end
                        end
                    end
                    DCA_RX_DOWN: begin
                        if (rx_vld) begin
                            if (rx_edge || clk_dly_q == 10'h000) begin
                                if (up_found_q && (!rx_edge || up_dist_q < dn_dist)) begin
                                    clk_dly_q <= init_q + up_dist_q;
                                end
                                rx_lock_q <= up_found_q || rx_edge;
                                rx_state_q <= (up_found_q || rx_edge) ? DCA_RX_TRACK
                                    : DCA_RX_IDLE;
                            end else begin
                                clk_dly_q <= clk_dly_q - 10'h001;
                            end
                        end
                    end
                    DCA_RX_TRACK: begin
                        if (rx_vld && rx_ctl_q[`DCA_RXC_TRACK]) begin
                            rx_lock_q <= rx_edge;
                            rx_lost_set <= rx_lock_q && !rx_edge;
                            if (smp_win_q.pre && clk_dly_q != 10'h000) begin
                                clk_dly_q <= clk_dly_q - 10'h001;
                            end else if (!smp_win_q.post && clk_dly_q != `DCA_DLY_MAX) begin
                                clk_dly_q <= clk_dly_q + 10'h001;
                            end
                        end
                    end
                    default: rx_state_q <= DCA_RX_IDLE;
                endcase
                // Give up rather than search forever on a dead link
                if ((rx_state_q == DCA_RX_UP || rx_state_q == DCA_RX_DOWN)
                    && rx_timer_q == 12'(`DCA_RX_LOCK_MAX_CLK - 1)) begin
                    rx_state_q <= DCA_RX_IDLE;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_lost_q <= 1'b0;
        end else if (rx_lost_set) begin
            rx_lost_q <= 1'b1;
        end else if (rx_ctl_q[`DCA_RXC_FLGCLR]) begin
            rx_lost_q <= 1'b0;
        end
    end

    // Domain phase loop
    dca_mu_state_t mu_state_q;
    logic [8:0] mu_dly_q, mu_init_q;
    logic mu_up_q, mu_have_prev_q, mu_lock_q, mu_lost_q;
    logic [4:0] mu_last_q;
    logic [2:0] mu_cnt_q;
    wire [8:0] guard_lo = {1'b0, guard_q[4:0], 3'b000};
    wire [8:0] guard_hi = `DCA_MU_MAX - guard_lo;
    // Five-bit wrap: 16 is half a turn, so the error is a signed offset
    wire [4:0] mu_err = mu_tgt_q - ph_q;
    wire [4:0] mu_err_abs = mu_err[4] ? 5'(-mu_err) : mu_err;
    wire mu_slope_meas = mu_up_q ? (mu_last_q > ph_q) : (mu_last_q < ph_q);
    wire mu_match = (ph_q == mu_tgt_q) && (ph_q != `DCA_MU_KEEPOUT) && mu_have_prev_q
        && (mu_slope_meas == mu_slope_neg_q);
    wire mu_step = ph_stable && mu_cnt_q == 3'(`DCA_MU_SETTLE_CLK - 1);
    wire mu_start = wr_hit(`DCA_A_MU_CTL) && wr_q.data[`DCA_MUC_RUN];
    wire mu_inc = (mu_err[4] == mu_slope_neg_q);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mu_state_q <= DCA_MU_IDLE;
            mu_dly_q <= `DCA_MU_RST;
            mu_init_q <= '0;
            mu_up_q <= 1'b1;
            mu_have_prev_q <= 1'b0;
            mu_last_q <= '0;
            mu_cnt_q <= '0;
            mu_lock_q <= 1'b0;
            mu_lost_q <= 1'b0;
        end else begin
            mu_cnt_q <= mu_step ? 3'h0 : (mu_cnt_q == 3'(`DCA_MU_SETTLE_CLK - 1)
                ? mu_cnt_q : mu_cnt_q + 3'h1);
            if (mu_start) begin
                mu_state_q <= DCA_MU_SEARCH;
                mu_init_q <= mu_dly_q;
                mu_up_q <= 1'b1;
                mu_have_prev_q <= 1'b0;
                mu_lock_q <= 1'b0;
                mu_lost_q <= 1'b0;
                mu_cnt_q <= '0;
            end else if (!mu_ctl_q[`DCA_MUC_RUN]) begin
                mu_state_q <= DCA_MU_IDLE;
                mu_lock_q <= 1'b0;
                if (wr_hit(`DCA_A_MU_HI)) mu_dly_q[0] <= wr_q.data[7];
                if (wr_hit(`DCA_A_MU_LO)) mu_dly_q[8:1] <= wr_q.data;
            end else if (mu_step) begin
                case (mu_state_q)
                    DCA_MU_SEARCH: begin
                        mu_last_q <= ph_q;
                        mu_have_prev_q <= 1'b1;
                        if (mu_match) begin
                            mu_state_q <= DCA_MU_TRACK;
                            mu_lock_q <= 1'b1;
                        end else if (mu_up_q && mu_dly_q >= guard_hi) begin
                            mu_up_q <= 1'b0;
                            mu_have_prev_q <= 1'b0;
                            mu_dly_q <= mu_init_q;
                        end else if (!mu_up_q && mu_dly_q <= guard_lo) begin
                            mu_up_q <= 1'b1;
                            mu_have_prev_q <= 1'b0;
                            mu_dly_q <= mu_init_q;
                            if (!guard_q[`DCA_GRD_RETRY]) mu_state_q <= DCA_MU_FAIL;
                        end else begin
                            mu_dly_q <= mu_up_q ? mu_dly_q + 9'h001 : mu_dly_q - 9'h001;
                        end
                    end
                    DCA_MU_TRACK: begin
                        if (mu_err_abs > `DCA_MU_LOSE) begin
                            mu_lock_q <= 1'b0;
                            if (mu_lock_q) mu_lost_q <= 1'b1;
                        end else if (mu_err_abs <= `DCA_MU_RELOCK) begin
                            mu_lock_q <= 1'b1;
                            mu_lost_q <= 1'b0;
                        end
                        if (mu_err != 5'h00) begin
                            if ((mu_inc && mu_dly_q == `DCA_MU_MAX)
                                || (!mu_inc && mu_dly_q == 9'h000)) begin
                                mu_lock_q <= 1'b0;
                                if (mu_lock_q) mu_lost_q <= 1'b1;
                                if (guard_q[`DCA_GRD_RESTART]) begin
                                    mu_state_q <= DCA_MU_SEARCH;
                                    mu_dly_q <= mu_init_q;
                                    mu_up_q <= 1'b1;
                                    mu_have_prev_q <= 1'b0;
                                end
                            end else begin
                                mu_dly_q <= mu_inc ? mu_dly_q + 9'h001 : mu_dly_q - 9'h001;
                            end
                        end
                    end
                    DCA_MU_IDLE, DCA_MU_FAIL: begin
                    end
                    default: mu_state_q <= DCA_MU_IDLE;
                endcase
            end
        end
    end

    // Event capture: status bit sets on a rising condition, held clear while disabled
    logic [3:0] cond_prev_q;
    wire [3:0] cond = {mu_lost_q, mu_lock_q, rx_lost_q, rx_lock_q};

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cond_prev_q <= '0;
            irq_st_q <= '0;
            irq_o <= 1'b0;
        end else begin
            cond_prev_q <= cond;
            irq_st_q <= irq_en_q & (irq_st_q | (cond & ~cond_prev_q));
            irq_o <= |(irq_st_q & irq_en_q);
        end
    end

    always_comb begin
        case (instr_addr)
            `DCA_A_PWR: rd_data = pwr_q;
            `DCA_A_IRQ_EN: rd_data = {4'h0, irq_en_q};
            `DCA_A_IRQ_ST: rd_data = {4'h0, irq_st_q};
            `DCA_A_RX_CTL: rd_data = rx_ctl_q;
            `DCA_A_SMP_LO: rd_data = smp_dly_q[7:0];
            `DCA_A_SMP_HI: rd_data = {6'h00, smp_dly_q[9:8]};
            `DCA_A_CLK_SKEW: rd_data = {clk_dly_q[1:0], skew_spare_q, skew_q};
            `DCA_A_CLK_HI: rd_data = clk_dly_q[9:2];
            `DCA_A_RX_ST: rd_data = {4'h0, rx_state_q == DCA_RX_UP || rx_state_q == DCA_RX_DOWN,
                rx_track_on, rx_lost_q, rx_lock_q};
            `DCA_A_MU_CTL: rd_data = mu_ctl_q;
            `DCA_A_MU_HI: rd_data = {mu_dly_q[0], mu_slope_neg_q, 1'b0, mu_tgt_q};
            `DCA_A_MU_LO: rd_data = mu_dly_q[8:1];
            `DCA_A_MU_GUARD: rd_data = guard_q;
            `DCA_A_MU_ST: rd_data = {6'h00, mu_lost_q, mu_lock_q};
            default: rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            input_clock_delay_o <= `DCA_DLY_RST;
            sample_clock_delay_o <= `DCA_DLY_RST;
            sampling_window_skew_o <= `DCA_SKEW_RST;
            domain_phase_delay_o <= `DCA_MU_RST;
            clock_out_power_down_o <= 1'b0;
            lvds_rx_power_down_o <= 1'b0;
        end else begin
            input_clock_delay_o <= clk_dly_q;
            // Sample register trails by a cycle while the loop runs; share the source
            sample_clock_delay_o <= (rx_state_q == DCA_RX_IDLE) ? smp_dly_q : clk_dly_q;
            sampling_window_skew_o <= skew_q;
            domain_phase_delay_o <= mu_dly_q;
            clock_out_power_down_o <= pwr_q[`DCA_PWR_CLKOUT];
            lvds_rx_power_down_o <= pwr_q[`DCA_PWR_LVDS];
        end
    end
endmodule

// ---- inc/dca_map.svh ----
`ifndef DCA_MAP_SVH
`define DCA_MAP_SVH

`define DCA_A_PWR 7'h01
`define DCA_A_IRQ_EN 7'h03
`define DCA_A_IRQ_ST 7'h04
`define DCA_A_RX_CTL 7'h10
`define DCA_A_SMP_LO 7'h11
`define DCA_A_SMP_HI 7'h12
`define DCA_A_CLK_SKEW 7'h13
`define DCA_A_CLK_HI 7'h14
`define DCA_A_RX_ST 7'h21
`define DCA_A_MU_CTL 7'h26
`define DCA_A_MU_HI 7'h27
`define DCA_A_MU_LO 7'h28
`define DCA_A_MU_GUARD 7'h29
`define DCA_A_MU_ST 7'h2A

`define DCA_PWR_CLKOUT 5
`define DCA_PWR_LVDS 4
`define DCA_RXC_TRACK 0
`define DCA_RXC_RUN 1
`define DCA_RXC_FLGCLR 2
`define DCA_MUC_RUN 0
`define DCA_GRD_RESTART 5
`define DCA_GRD_RETRY 6

`define DCA_DLY_MAX 10'h180
`define DCA_DLY_RST 10'h0A7
`define DCA_SKEW_RST 4'h0
`define DCA_MU_MAX 9'h1B0
`define DCA_MU_RST 9'h0D8
`define DCA_MU_TGT_RST 5'h00
`define DCA_GUARD_RST 8'h00
`define DCA_MU_KEEPOUT 5'h00
`define DCA_MU_LOSE 5'h04
`define DCA_MU_RELOCK 5'h03

`define DCA_CLK_NS 25
`define DCA_DAC_PER_CLK 64
`define DCA_RX_LOCK_MAX_DAC 135000
`define DCA_RX_LOCK_MAX_CLK (`DCA_RX_LOCK_MAX_DAC / `DCA_DAC_PER_CLK)
`define DCA_MU_SETTLE_NS 100
`define DCA_MU_SETTLE_CLK ((`DCA_MU_SETTLE_NS + `DCA_CLK_NS - 1) / `DCA_CLK_NS)

`endif

// ---- inc/dca_pkg.sv ----
package dca_pkg;
    typedef enum logic [1:0] {
        DCA_RX_IDLE = 2'b00,
        DCA_RX_UP = 2'b01,
        DCA_RX_DOWN = 2'b10,
        DCA_RX_TRACK = 2'b11
    } dca_rx_state_t;

    typedef enum logic [1:0] {
        DCA_MU_IDLE = 2'b00,
        DCA_MU_SEARCH = 2'b01,
        DCA_MU_TRACK = 2'b10,
        DCA_MU_FAIL = 2'b11
    } dca_mu_state_t;

    typedef struct packed {
        logic pre;
        logic post;
    } dca_window_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
    } dca_wr_t;
endpackage

// ---- tb/dca_align_ctrl_asserts.sv ----
`timescale 1ns/100ps
module dca_align_ctrl_asserts (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic spi_csb_i,
    input wire logic spi_sdio_oe_n_o,
    input wire logic irq_o,
    input wire logic [9:0] input_clock_delay_o,
    input wire logic [9:0] sample_clock_delay_o,
    input wire logic [3:0] sampling_window_skew_o,
    input wire logic [8:0] domain_phase_delay_o,
    input wire logic clock_out_power_down_o,
    input wire logic lvds_rx_power_down_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Long enough for any write launched by the last frame to have landed
    sequence s_quiet;
        spi_csb_i [*8];
    endsequence
    a_clk_dly_range: assert property (input_clock_delay_o <= 10'h180)
        else $error("clock delay out of range");
    a_smp_dly_range: assert property (sample_clock_delay_o <= 10'h180)
        else $error("sample delay out of range");
    a_phase_dly_range: assert property (domain_phase_delay_o <= 9'h1B0)
        else $error("phase delay out of range");
    a_oe_released: assert property (s_quiet |-> spi_sdio_oe_n_o)
        else $error("data pin driven while deselected");
    a_pd_hold: assert property (s_quiet |-> $stable({clock_out_power_down_o, lvds_rx_power_down_o}))
        else $error("power down changed without a write");
    a_skew_hold: assert property (s_quiet |-> $stable(sampling_window_skew_o))
        else $error("skew changed without a write");
    a_dly_together: assert property (s_quiet ##0 $changed(input_clock_delay_o)
        |-> input_clock_delay_o == sample_clock_delay_o)
        else $error("loop moved delays apart");
    a_irq_reset: assert property ($rose(rst_n_i) |-> !irq_o)
        else $error("irq set out of reset");
endmodule

bind dca_align_ctrl dca_align_ctrl_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .spi_csb_i(spi_csb_i), .spi_sdio_oe_n_o(spi_sdio_oe_n_o), .irq_o(irq_o),
    .input_clock_delay_o(input_clock_delay_o), .sample_clock_delay_o(sample_clock_delay_o),
    .sampling_window_skew_o(sampling_window_skew_o),
    .domain_phase_delay_o(domain_phase_delay_o),
    .clock_out_power_down_o(clock_out_power_down_o),
    .lvds_rx_power_down_o(lvds_rx_power_down_o));

// ---- tb/dca_host_model.sv ----
`timescale 1ns/100ps
module dca_host_model (
    input wire logic [9:0] dly_i,
    input wire logic [9:0] shift_i,
    output logic lclk_o,
    output dca_pkg::dca_window_t window_o
);
    import dca_pkg::*;
    logic [9:0] d;
    logic [9:0] e;
    initial lclk_o = 1'b0;
    // Host data clock is continuous once the link is up
    always #7.5 lclk_o = ~lclk_o;
    assign d = dly_i - shift_i;
    // Two data clock edges in range; shift_i models skew drift
    assign e = (d >= 10'h0A0) ? 10'h0B4 : 10'h08C;
    assign window_o = '{pre: (d > e), post: (d >= e)};
endmodule

// ---- tb/tb_dca_align_ctrl.sv ----
`timescale 1ns/100ps
module tb_dca_align_ctrl;
    import dca_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sclk = 1'b0;
    logic csb = 1'b1;
    logic sdi = 1'b0;
    logic sdo, oe_n, irq, cpd, lpd, lclk;
    logic [9:0] cdly, sdly;
    logic [9:0] shift = 10'h000;
    logic [3:0] skew;
    logic [8:0] pdly;
    logic [4:0] ph;
    // Phase falls as the digital delay grows, passing the target just above 216
    assign ph = 5'(9'h0DF - pdly);
    logic [7:0] rd;
    dca_window_t win;
    int num_errors = 0;
    int checked = 0;
    int cyc = 0;
    initial forever #12.5 clk_i = ~clk_i;
    dca_host_model HOST (.dly_i(cdly), .shift_i(shift), .lclk_o(lclk), .window_o(win));
    dca_align_ctrl DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .host_data_clock_in_i(lclk),
        .spi_sclk_i(sclk), .spi_csb_i(csb), .spi_sdio_i(sdi), .spi_sdio_o(sdo),
        .spi_sdio_oe_n_o(oe_n), .window_i(win), .domain_phase_i(ph), .irq_o(irq),
        .input_clock_delay_o(cdly), .sample_clock_delay_o(sdly),
        .sampling_window_skew_o(skew), .domain_phase_delay_o(pdly),
        .clock_out_power_down_o(cpd), .lvds_rx_power_down_o(lpd));
    task automatic end_of_test();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Six core clocks per serial phase keeps clear of the synchroniser lag
    task automatic spi(input logic [15:0] w);
        csb = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = w[i];
            repeat (6) @(negedge clk_i);
            rd[i[2:0]] = sdo;
            sclk = 1'b1;
            repeat (6) @(negedge clk_i);
            sclk = 1'b0;
        end
        repeat (6) @(negedge clk_i);
        csb = 1'b1;
        repeat (6) @(negedge clk_i);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        spi({1'b0, a, d});
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        spi({1'b1, a, 8'h00});
        cmp(32'(rd), 32'(e));
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        cmp(32'({cdly, sdly, pdly, irq}), 32'({10'h0A7, 10'h0A7, 9'h0D8, 1'b0}));
        rd_chk(7'h28, 8'h6C);
        rd_chk(7'h7F, 8'h00);
        wr(7'h01, 8'h30);
        cmp(32'({cpd, lpd}), 32'h3);
        wr(7'h01, 8'h20);
        cmp(32'({cpd, lpd}), 32'h2);
        $display("test reset and power done");
        wr(7'h27, 8'h46);
        wr(7'h28, 8'h6C);
        wr(7'h29, 8'hCB);
        wr(7'h26, 8'h03);
        rd_chk(7'h2A, 8'h01);
        cmp(32'(pdly), 32'h0D9);
        $display("test phase lock done");
        wr(7'h13, 8'h72);
        wr(7'h11, 8'hA5);
        cmp(32'({skew, cdly, sdly}), 32'({4'h2, 10'h0A5, 10'h0A5}));
        wr(7'h03, 8'h03);
        wr(7'h10, 8'h00);
        wr(7'h10, 8'h02);
        wr(7'h10, 8'h03);
        repeat (2200) @(negedge clk_i);
        rd_chk(7'h21, 8'h05);
        cmp(32'({cdly, sdly}), 32'({10'h0B4, 10'h0B4}));
        rd_chk(7'h14, 8'h2D);
        rd_chk(7'h11, 8'hB4);
        $display("test acquire done");
        shift = 10'h002;
        repeat (400) @(negedge clk_i);
        rd_chk(7'h21, 8'h07);
        rd_chk(7'h04, 8'h03);
        cmp(32'({irq, cdly}), 32'({1'b1, 10'h0B6}));
        wr(7'h10, 8'h07);
        wr(7'h10, 8'h03);
        rd_chk(7'h21, 8'h05);
        wr(7'h03, 8'h00);
        rd_chk(7'h04, 8'h00);
        cmp(32'({irq, oe_n}), 32'h1);
        $display("test track and lost lock done");
        end_of_test();
    end
endmodule
